// file: acc_pkg.sv
// acc_pkg: offsets, fields, reset values, counts and types of the
// converter control block
// assumes a 32-bit AXI4-Lite slave with all writable fields in byte lane 0 of each word
package acc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_INPUT_SEL = 8'h04;
    localparam logic [7:0] OFS_TRIG_SEL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int BIT_EN = 7;
    localparam int BIT_START = 6;
    localparam int BIT_AUTO = 5;
    localparam int BIT_DONE = 4;
    localparam int BIT_IE = 3;
    localparam int BIT_BUSY = 8;
    localparam int BIT_INIT = 9;
    localparam int DIV_W = 3;
    localparam int SEL_W = 5;
    localparam int TRIG_W = 3;
    localparam int RES_W = 10;
    localparam int CYC_W = 5;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_W = 2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
    localparam logic [TRIG_W-1:0] TRIG_RST = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    // ------------------------------------------------------------
    // conversion lengths in converter clock cycles
    // ------------------------------------------------------------
    localparam logic [CYC_W-1:0] FIRST_CYCLES = 5'h19;
    localparam logic [CYC_W-1:0] NORMAL_CYCLES = 5'h0D;
    // ------------------------------------------------------------
    // selector code boundaries, the free-run trigger code and bus response codes
    // ------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_DIFF_LO = 5'h08;
    localparam logic [SEL_W-1:0] SEL_G1_LO = 5'h10;
    localparam logic [SEL_W-1:0] SEL_NEG2_LO = 5'h18;
    localparam logic [SEL_W-1:0] SEL_BANDGAP = 5'h1E;
    localparam logic [SEL_W-1:0] SEL_GROUND = 5'h1F;
    localparam logic [TRIG_W-1:0] TRIG_FREE = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_SINGLE, MODE_DIFF, MODE_BANDGAP, MODE_GROUND} acc_mode_t;
    typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} acc_gain_t;
    typedef enum logic {ST_IDLE, ST_CONV} acc_state_t;
endpackage

// file: acc_prescaler.sv
// acc_prescaler: divides the system clock into converter clock ticks
// assumes the caller holds run low while the converter is off
`timescale 1ns/1ns
`default_nettype none
module acc_prescaler #(
    parameter int DIV_W = 3,
    parameter int CNT_W = 7
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic tick_o
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] last;
    logic wrap;

    // codes 0 and 1 both divide by two
    function automatic logic [CNT_W-1:0] div_last(input logic [DIV_W-1:0] code);
        logic [CNT_W:0] full;
        full = (CNT_W+1)'(1) << code;
        if (code <= (DIV_W)'(1)) begin
            div_last = (CNT_W)'(1);
        end else begin
            div_last = full[CNT_W-1:0] - (CNT_W)'(1);
        end
    endfunction

    assign last = div_last(div_i);
    assign wrap = cnt_r >= last;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= wrap ? '0 : cnt_r + (CNT_W)'(1);
            tick_o <= wrap;
        end
    end
endmodule
`default_nettype wire

// file: acc_top.sv
// acc_top: control of a 10-bit successive-approximation converter
// assumes an AXI4-Lite master and an analog core that counts on the
// registered channel selection, tick and start outputs
`timescale 1ns/1ns
`default_nettype none
module acc_top
    import acc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NUM_TRIG = 7
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [NUM_TRIG-1:0] TRIG_FLAGS_I,
    input wire logic GLOBAL_IE_I,
    input wire logic VECTOR_ACK_I,
    input wire logic [acc_pkg::RES_W-1:0] RESULT_I,
    output logic CONVERTER_ON_O,
    output logic CONV_TICK_O,
    output logic CONV_START_O,
    output logic CONV_BUSY_O,
    output logic CONV_INIT_O,
    output acc_pkg::acc_mode_t CH_MODE_O,
    output logic [2:0] CH_POS_O,
    output logic [2:0] CH_NEG_O,
    output acc_pkg::acc_gain_t CH_GAIN_O,
    output logic CONV_IRQ_O,
    output logic IRQ_O
);
    import acc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic aw_full_r;
    logic w_full_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic en_r;
    logic auto_r;
    logic done_r;
    logic ie_r;
    logic [DIV_W-1:0] div_r;
    logic [SEL_W-1:0] sel_pend_r;
    logic [SEL_W-1:0] sel_act_r;
    logic [TRIG_W-1:0] trig_sel_r;
    logic trig_lvl_r;
    logic init_pend_r;
    acc_state_t state_r;
    logic [CYC_W-1:0] len_r;
    logic [CYC_W-1:0] cnt_r;
    logic [RES_W-1:0] result_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic tick;

    // ------------------------------------------------------------
    // channel decode
    // ------------------------------------------------------------
    // packs mode, positive, negative and gain
    function automatic logic [9:0] sel_decode(input logic [SEL_W-1:0] c);
        acc_mode_t m;
        acc_gain_t g;
        logic [2:0] p;
        logic [2:0] n;
        m = MODE_DIFF;
        g = GAIN_1X;
        p = c[2:0];
        n = 3'h0;
        if (c < SEL_DIFF_LO) begin
            m = MODE_SINGLE;
        end else if (c < SEL_G1_LO) begin
            p = {1'b0, c[2], c[0]};
            n = {1'b0, c[2], 1'b0};
            g = c[1] ? GAIN_200X : GAIN_10X;
        end else if (c < SEL_NEG2_LO) begin
            n = 3'h1;
        end else if (c < SEL_BANDGAP) begin
            n = 3'h2;
        end else if (c == SEL_BANDGAP) begin
            m = MODE_BANDGAP;
            p = 3'h0;
        end else begin
            m = MODE_GROUND;
            p = 3'h0;
        end
        sel_decode = {m, p, n, g};
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic ar_hs;
    logic rvalid_nxt;
    logic aw_full_nxt;
    logic w_full_nxt;
    logic lane0;
    logic wr_ctrl;
    logic wr_sel;
    logic wr_trig;
    logic wr_iclr;
    logic wr_ien;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_data;
    logic [7:0] ctrl_rd;
    logic [7:0] wd;

    assign aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    assign w_hs = S_AXI_WVALID_I & S_AXI_WREADY_O;
    assign do_write = aw_full_r & w_full_r & ~S_AXI_BVALID_O;
    assign aw_full_nxt = (aw_full_r | aw_hs) & ~do_write;
    assign w_full_nxt = (w_full_r | w_hs) & ~do_write;
    assign ar_hs = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    assign rvalid_nxt = ar_hs | (S_AXI_RVALID_O & ~S_AXI_RREADY_I);
    assign lane0 = do_write & w_strb_r[0];
    assign wd = w_data_r[7:0];
    assign wr_ctrl = lane0 & (aw_addr_r == ADDR_W'(OFS_CTRL_A));
    assign wr_sel = lane0 & (aw_addr_r == ADDR_W'(OFS_INPUT_SEL));
    assign wr_trig = lane0 & (aw_addr_r == ADDR_W'(OFS_TRIG_SEL));
    assign wr_iclr = lane0 & (aw_addr_r == ADDR_W'(OFS_IRQ_CLR));
    assign wr_ien = lane0 & (aw_addr_r == ADDR_W'(OFS_IRQ_EN));
    assign wr_hit = (aw_addr_r == ADDR_W'(OFS_CTRL_A))
        | (aw_addr_r == ADDR_W'(OFS_INPUT_SEL))
        | (aw_addr_r == ADDR_W'(OFS_TRIG_SEL))
        | (aw_addr_r == ADDR_W'(OFS_STATUS))
        | (aw_addr_r == ADDR_W'(OFS_RESULT))
        | (aw_addr_r == ADDR_W'(OFS_IRQ_STAT))
        | (aw_addr_r == ADDR_W'(OFS_IRQ_CLR))
        | (aw_addr_r == ADDR_W'(OFS_IRQ_EN));

    // start bit reads back the busy state
    assign ctrl_rd = {en_r, state_r == ST_CONV, auto_r, done_r, ie_r, 2'h0, 1'b0}
        | {5'h00, div_r};

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR_I)
            ADDR_W'(OFS_CTRL_A): rd_data[7:0] = ctrl_rd;
            ADDR_W'(OFS_INPUT_SEL): rd_data[SEL_W-1:0] = sel_pend_r;
            ADDR_W'(OFS_TRIG_SEL): rd_data[TRIG_W-1:0] = trig_sel_r;
            ADDR_W'(OFS_STATUS): begin
                rd_data[SEL_W-1:0] = sel_act_r;
                rd_data[BIT_BUSY] = state_r == ST_CONV;
                rd_data[BIT_INIT] = init_pend_r;
            end
            ADDR_W'(OFS_RESULT): rd_data[RES_W-1:0] = result_r;
            ADDR_W'(OFS_IRQ_STAT): rd_data[IRQ_W-1:0] = irq_stat_r;
            ADDR_W'(OFS_IRQ_EN): rd_data[IRQ_W-1:0] = irq_en_r;
            ADDR_W'(OFS_IRQ_CLR): rd_hit = 1'b1;
            default: rd_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // conversion control
    // ------------------------------------------------------------
    logic en_nxt;
    logic enabling;
    logic abort;
    logic sw_start;
    logic trig_now;
    logic auto_go;
    logic busy;
    logic fin;
    logic free_mode;
    logic rerun;
    logic start_go;
    logic init_use;
    logic done_set;
    logic done_clr;
    logic done_nxt;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_stat_nxt;
    logic [IRQ_W-1:0] irq_en_nxt;
    logic [SEL_W-1:0] sel_act_nxt;
    acc_state_t state_nxt;

    assign busy = state_r == ST_CONV;
    assign en_nxt = wr_ctrl ? wd[BIT_EN] : en_r;
    assign enabling = en_nxt & ~en_r;
    assign abort = en_r & ~en_nxt & busy;
    assign sw_start = wr_ctrl & wd[BIT_START];
    assign free_mode = auto_r & (trig_sel_r == TRIG_FREE);
    // free running has no edge source, so entering it cannot trigger
    assign trig_now = (trig_sel_r != TRIG_FREE)
        & TRIG_FLAGS_I[trig_sel_r - 3'h1];
    assign auto_go = auto_r & trig_now & ~trig_lvl_r;
    assign fin = busy & tick & (cnt_r == len_r - CYC_W'(1));
    assign rerun = fin & free_mode;
    assign start_go = en_nxt & ((~busy & (sw_start | auto_go)) | rerun);
    assign init_use = init_pend_r | enabling;

    always_comb begin
        state_nxt = state_r;
        if (abort) begin
            state_nxt = ST_IDLE;
        end else if (start_go) begin
            state_nxt = ST_CONV;
        end else if (fin) begin
            state_nxt = ST_IDLE;
        end
    end

    // selector held steady while converting
    assign sel_act_nxt = (busy & ~fin) ? sel_act_r : sel_pend_r;

    assign done_set = fin;
    assign done_clr = (wr_ctrl & wd[BIT_DONE]) | VECTOR_ACK_I;
    assign done_nxt = done_set | (done_r & ~done_clr);
    assign irq_ev = {abort, fin};
    assign irq_stat_nxt = irq_ev | (irq_stat_r & ~(wr_iclr ? wd[IRQ_W-1:0] : IRQ_RST));
    assign irq_en_nxt = wr_ien ? wd[IRQ_W-1:0] : irq_en_r;

    // ------------------------------------------------------------
    // converter clock
    // ------------------------------------------------------------
    acc_prescaler #(
        .DIV_W(DIV_W),
        .CNT_W(7)
    ) u_prescaler (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .run_i(en_r),
        .div_i(div_r),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // bus registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            S_AXI_AWREADY_O <= ~aw_full_nxt;
            S_AXI_WREADY_O <= ~w_full_nxt;
            if (do_write) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            if (aw_hs) aw_addr_r <= S_AXI_AWADDR_I;
            if (w_hs) w_data_r <= S_AXI_WDATA_I;
            if (w_hs) w_strb_r <= S_AXI_WSTRB_I;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= ~rvalid_nxt;
            S_AXI_RVALID_O <= rvalid_nxt;
            if (ar_hs) begin
                S_AXI_RDATA_O <= rd_data;
                S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            en_r <= CTRL_A_RST[BIT_EN];
            auto_r <= CTRL_A_RST[BIT_AUTO];
            ie_r <= CTRL_A_RST[BIT_IE];
            div_r <= CTRL_A_RST[DIV_W-1:0];
            done_r <= CTRL_A_RST[BIT_DONE];
            sel_pend_r <= SEL_RST;
            trig_sel_r <= TRIG_RST;
            irq_stat_r <= IRQ_RST;
            irq_en_r <= IRQ_RST;
        end else begin
            en_r <= en_nxt;
            if (wr_ctrl) auto_r <= wd[BIT_AUTO];
            if (wr_ctrl) ie_r <= wd[BIT_IE];
            if (wr_ctrl) div_r <= wd[DIV_W-1:0];
            done_r <= done_nxt;
            if (wr_sel) sel_pend_r <= wd[SEL_W-1:0];
            if (wr_trig) trig_sel_r <= wd[TRIG_W-1:0];
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_r <= ST_IDLE;
            init_pend_r <= 1'b0;
            len_r <= NORMAL_CYCLES;
            cnt_r <= '0;
            trig_lvl_r <= 1'b0;
            sel_act_r <= SEL_RST;
            result_r <= '0;
        end else begin
            state_r <= state_nxt;
            trig_lvl_r <= trig_now;
            sel_act_r <= sel_act_nxt;
            if (start_go) begin
                len_r <= init_use ? FIRST_CYCLES : NORMAL_CYCLES;
                cnt_r <= '0;
            end else if (busy & tick) begin
                cnt_r <= cnt_r + CYC_W'(1);
            end
            if (start_go) begin
                init_pend_r <= 1'b0;
            end else if (enabling) begin
                init_pend_r <= 1'b1;
            end
            if (fin) result_r <= RESULT_I;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            CONVERTER_ON_O <= 1'b0;
            CONV_TICK_O <= 1'b0;
            CONV_START_O <= 1'b0;
            CONV_BUSY_O <= 1'b0;
            CONV_INIT_O <= 1'b0;
            {CH_MODE_O, CH_POS_O, CH_NEG_O, CH_GAIN_O} <= sel_decode(SEL_RST);
            CONV_IRQ_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            CONVERTER_ON_O <= en_nxt;
            CONV_TICK_O <= tick;
            CONV_START_O <= start_go;
            CONV_BUSY_O <= state_nxt == ST_CONV;
            if (start_go) CONV_INIT_O <= init_use;
            {CH_MODE_O, CH_POS_O, CH_NEG_O, CH_GAIN_O} <= sel_decode(sel_act_nxt);
            CONV_IRQ_O <= done_nxt & ie_r & GLOBAL_IE_I;
            IRQ_O <= |(irq_stat_nxt & irq_en_nxt);
        end
    end
endmodule
`default_nettype wire

// file: acc_chk.sv
// acc_chk: port-level assertions for acc_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module acc_chk
    import acc_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic GLOBAL_IE_I,
    input wire logic VECTOR_ACK_I,
    input wire logic CONVERTER_ON_O,
    input wire logic CONV_TICK_O,
    input wire logic CONV_START_O,
    input wire logic CONV_BUSY_O,
    input wire logic CONV_INIT_O,
    input wire acc_pkg::acc_mode_t CH_MODE_O,
    input wire logic [2:0] CH_POS_O,
    input wire logic [2:0] CH_NEG_O,
    input wire acc_pkg::acc_gain_t CH_GAIN_O,
    input wire logic CONV_IRQ_O
);
    logic [7:0] tick_cnt_r;
    logic [7:0] tick_cnt_nxt;
    // ticks seen while busy since the last conversion start
    assign tick_cnt_nxt = CONV_START_O ? 8'h00 : tick_cnt_r + {7'h00, CONV_TICK_O & CONV_BUSY_O};
    always_ff @(posedge REF_CLK_I) begin
        tick_cnt_r <= RST_N_I ? tick_cnt_nxt : 8'h00;
    end
    default clocking dcb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    irq_gate_a: assert property (CONV_IRQ_O |-> $past(GLOBAL_IE_I))
        else $error("request without global enable");
    ack_clear_a: assert property (VECTOR_ACK_I && !CONV_BUSY_O |-> ##[1:2] !CONV_IRQ_O)
        else $error("request stays after vector taken");
    start_pulse_a: assert property (CONV_START_O |-> CONV_BUSY_O ##1 !CONV_START_O)
        else $error("start pulse malformed");
    busy_start_a: assert property ($rose(CONV_BUSY_O) |-> ##[0:2] CONV_START_O)
        else $error("busy without start pulse");
    abort_stop_a: assert property ($fell(CONVERTER_ON_O) |-> ##[0:2] !CONV_BUSY_O)
        else $error("conversion survives disable");
    neg_zero_a: assert property (CH_MODE_O != MODE_DIFF |-> CH_NEG_O == 3'h0)
        else $error("negative input set outside differential mode");
    sel_hold_a: assert property (
        CONV_BUSY_O && $past(CONV_BUSY_O, 2) && $changed({CH_MODE_O, CH_POS_O, CH_NEG_O, CH_GAIN_O})
        |-> (CONV_START_O || $past(CONV_START_O)) or ##[1:2] CONV_START_O)
        else $error("channel changed inside a conversion");
    conv_len_a: assert property ($fell(CONV_BUSY_O) ##1 CONVERTER_ON_O |->
        ($past(CONV_INIT_O) ? ($past(tick_cnt_r) inside {[24:26]})
        : ($past(tick_cnt_r) inside {[12:14]})))
        else $error("conversion length wrong");
endmodule
bind acc_top acc_chk i_chk (.*);
`default_nettype wire

// file: test_adc_channel_and_control.sv
// test_adc_channel_and_control: register-level bench of acc_top
// assumes acc_pkg, acc_top and acc_chk compiled first
`timescale 1ns/1ns
`default_nettype none
module test_adc_channel_and_control;
    import acc_pkg::*;
    logic REF_CLK_I = 1'b0, RST_N_I = 1'b0, GLOBAL_IE_I = 1'b0, VECTOR_ACK_I = 1'b0;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
    logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
    logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
    logic [31:0] S_AXI_WDATA_I = 32'h0;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic [6:0] TRIG_FLAGS_I = 7'h00;
    logic [9:0] RESULT_I = 10'h2A5;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, rsp;
    logic [31:0] S_AXI_RDATA_O, rd;
    logic CONVERTER_ON_O, CONV_TICK_O, CONV_START_O, CONV_BUSY_O, CONV_INIT_O, CONV_IRQ_O, IRQ_O;
    acc_mode_t CH_MODE_O;
    acc_gain_t CH_GAIN_O;
    logic [2:0] CH_POS_O, CH_NEG_O;
    // channel code, expected {mode, pos, neg, gain}
    logic [4:0] codes [7] = '{5'h03, 5'h0A, 5'h0D, 5'h13, 5'h1D, 5'h1E, 5'h1F};
    logic [9:0] exps [7] = '{10'h060, 10'h102, 10'h169, 10'h164, 10'h1A8, 10'h200, 10'h300};
    logic [9:0] prev = 10'h000;
    int err_total = 0;
    int checks = 0;
    int n;
    int s;
    acc_top i_dut (.*);
    initial begin
        forever #2 REF_CLK_I = ~REF_CLK_I;
    end
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic tmo;
        if (n >= 2000) begin
            chk(32'h1, 32'h0, "wait ran out");
            tally_and_finish();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge REF_CLK_I);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= d;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        for (n = 0; n < 2000; n++) begin
            @(posedge REF_CLK_I);
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
            if (S_AXI_BVALID_O) break;
        end
        rsp = S_AXI_BRESP_O;
        tmo();
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        for (n = 0; n < 2000; n++) begin
            @(posedge REF_CLK_I);
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
            if (S_AXI_RVALID_O) break;
        end
        rd = S_AXI_RDATA_O;
        rsp = S_AXI_RRESP_O;
        tmo();
        chk(rd, e, $sformatf("read %0h", a));
    endtask
    task automatic idle;
        for (n = 0; n < 2000 && CONV_BUSY_O !== 1'b0; n++) @(posedge REF_CLK_I);
        tmo();
    endtask
    task automatic gap;
        for (n = 0; n < 300 && CONV_TICK_O !== 1'b1; n++) @(posedge REF_CLK_I);
        n = 0;
        do begin
            @(posedge REF_CLK_I);
            n++;
        end while (CONV_TICK_O !== 1'b1 && n < 300);
        if (CONV_TICK_O !== 1'b1) n = 2000;
        tmo();
    endtask
    function automatic logic [9:0] msk(input logic [9:0] e);
        return e & (e[9:8] == 2'h1 ? 10'h3FF : e[9:8] == 2'h0 ? 10'h3FC : 10'h31C);
    endfunction
    initial begin
        cyc(6);
        RST_N_I <= 1'b1;
        cyc(1);
        rc(OFS_CTRL_A, 32'h0);
        rc(OFS_INPUT_SEL, 32'h0);
        rc(8'h20, 32'h0);
        chk(rsp, RESP_SLVERR, "unmapped response");
        wr(8'h20, 32'hFF);
        chk(rsp, RESP_SLVERR, "unmapped write");
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            wr(OFS_CTRL_A, {24'h0, 5'h10, k[2:0]});
            gap();
            gap();
            chk(n, 2 << (k == 0 ? 0 : k - 1), "tick spacing");
        end
        $display("test divider done");
        wr(OFS_CTRL_A, 32'h00);
        chk(rsp, RESP_OKAY, "write response");
        wr(OFS_CTRL_A, 32'hC8);
        chk(CONV_BUSY_O, 1'b1, "busy after start");
        chk(CONVERTER_ON_O, 1'b1, "converter on");
        rc(OFS_CTRL_A, 32'hC8);
        chk(CONV_INIT_O, 1'b1, "first conversion");
        idle();
        rc(OFS_CTRL_A, 32'h98);
        rc(OFS_RESULT, 32'h2A5);
        chk(CONV_IRQ_O, 1'b0, "request without global enable");
        GLOBAL_IE_I <= 1'b1;
        cyc(2);
        chk(CONV_IRQ_O, 1'b1, "request");
        VECTOR_ACK_I <= 1'b1;
        cyc(1);
        VECTOR_ACK_I <= 1'b0;
        cyc(2);
        rc(OFS_CTRL_A, 32'h88);
        wr(OFS_CTRL_A, 32'h88);
        chk(CONV_BUSY_O, 1'b0, "start zero");
        wr(OFS_CTRL_A, 32'hC8);
        idle();
        chk(CONV_INIT_O, 1'b0, "later conversion");
        wr(OFS_CTRL_A, 32'h98);
        rc(OFS_CTRL_A, 32'h88);
        $display("test conversion done");
        for (int k = 0; k < 7; k++) begin
            wr(OFS_CTRL_A, 32'hC0);
            wr(OFS_INPUT_SEL, {27'h0, codes[k]});
            chk(msk({CH_MODE_O, CH_POS_O, CH_NEG_O, CH_GAIN_O}), prev, "held");
            idle();
            prev = msk(exps[k]);
            chk(msk({CH_MODE_O, CH_POS_O, CH_NEG_O, CH_GAIN_O}), prev, "chan");
        end
        $display("test selector done");
        wr(OFS_IRQ_CLR, 32'h3);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_CTRL_A, 32'hC0);
        wr(OFS_CTRL_A, 32'h00);
        cyc(3);
        chk(CONV_BUSY_O, 1'b0, "abort");
        chk(CONVERTER_ON_O, 1'b0, "converter off");
        rc(OFS_CTRL_A, 32'h10);
        rc(OFS_IRQ_STAT, 32'h2);
        chk(IRQ_O, 1'b0, "masked event");
        wr(OFS_IRQ_EN, 32'h3);
        cyc(2);
        chk(IRQ_O, 1'b1, "enabled event");
        wr(OFS_IRQ_CLR, 32'h2);
        cyc(2);
        chk(IRQ_O, 1'b0, "cleared event");
        $display("test abort done");
        wr(OFS_TRIG_SEL, 32'h3);
        wr(OFS_CTRL_A, 32'hA0);
        TRIG_FLAGS_I <= 7'h7B;
        cyc(4);
        chk(CONV_BUSY_O, 1'b0, "other flag");
        TRIG_FLAGS_I <= 7'h7F;
        cyc(4);
        chk(CONV_BUSY_O, 1'b1, "trigger edge");
        idle();
        wr(OFS_TRIG_SEL, 32'h0);
        cyc(4);
        chk(CONV_BUSY_O, 1'b0, "switch to free run");
        wr(OFS_CTRL_A, 32'hE0);
        s = 0;
        for (n = 0; n < 200; n++) begin
            @(posedge REF_CLK_I);
            s += (CONV_START_O === 1'b1);
        end
        chk(s > 2, 1'b1, "free run restarts");
        wr(OFS_CTRL_A, 32'h00);
        $display("test trigger done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
